// ---- design/cds_pkg.sv ----
// Purpose: constants for the front-end serial control block
// Assumes: ref_clk at 10 MHz, serial clock at most 5 MHz
// Notes:   register fields given as low bit and width
package cds_pkg;

  // ---------------------------------------------
  // clock and serial timing
  // ---------------------------------------------
  localparam int REF_CLK_PERIOD_NS = 100;
  localparam int SCK_MIN_PERIOD_NS = 200;
  localparam int SCK_MIN_PERIOD_CYC =
    (SCK_MIN_PERIOD_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

  // ---------------------------------------------
  // frame layout
  // ---------------------------------------------
  localparam int FRAME_BITS   = 24;
  localparam int BYTE_BITS    = 8;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 16;
  localparam int CNT_W        = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
  localparam logic [CNT_W-1:0] CNT_OVER = 5'h19;

  // ---------------------------------------------
  // register addresses
  // ---------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_FRONTEND_FIRST    = 8'hf0;
  localparam logic [ADDR_W-1:0] ADDR_FRONTEND_LAST     = 8'hf8;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_AND_BIAS     = 8'hf0;
  localparam logic [ADDR_W-1:0] ADDR_POWER_FILTER      = 8'hf1;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP_PATH        = 8'hf2;

  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int GAIN_LSB        = 0;
  localparam int GAIN_W          = 8;
  localparam int FE_BIAS_LSB     = 13;
  localparam int FE_BIAS_W       = 3;
  localparam int SLEEP_BIT       = 0;
  localparam int STANDBY_BIT     = 1;
  localparam int TEST_MODE_LSB   = 2;
  localparam int TEST_MODE_W     = 3;
  localparam int SHA_BW_LSB      = 8;
  localparam int SHA_BW_W        = 2;
  localparam int BLACK_TC_LSB    = 10;
  localparam int BLACK_TC_W      = 4;
  localparam int ADC_BIAS_LSB    = 14;
  localparam int ADC_BIAS_W      = 2;
  localparam int INPUT_PATH_BIT  = 14;

  // ---------------------------------------------
  // reset values
  // ---------------------------------------------
  localparam logic [GAIN_W-1:0]      GAIN_RESET      = 8'h00;
  localparam logic [FE_BIAS_W-1:0]   FE_BIAS_RESET   = 3'h4;
  localparam logic [TEST_MODE_W-1:0] TEST_MODE_RESET = 3'h0;
  localparam logic [SHA_BW_W-1:0]    SHA_BW_RESET    = 2'h0;
  localparam logic [BLACK_TC_W-1:0]  BLACK_TC_RESET  = 4'h0;
  localparam logic [ADC_BIAS_W-1:0]  ADC_BIAS_RESET  = 2'h0;

endpackage

// ---- design/level_sync.sv ----
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: inputs are asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module level_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [31:0] RESET_VAL = 32'h0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // ---------------------------------------------
  // per-bit flop pairs
  // ---------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg[i] <= RESET_VAL[i];
          q[i]        <= RESET_VAL[i];
        end else begin
          meta_reg[i] <= d[i];
          q[i]        <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule

// ---- design/cds_serial_control_regs.sv ----
// Purpose: serial control port and front-end registers
// Assumes: host writes 24-bit frames, serial clock sampled on ref_clk
// Notes:   registers are write only; complete 24-bit frames also leave on frame_addr and frame_data
//
// What this block does
// - three bytes form one continuous frame
// - short frame is dropped, registers unchanged
// - reset restores every register default
// - address byte selects one of 256
// - front-end registers live at f0 to f8
// - f0 bits 7:0 hold gain code
// - same gain code sets direct-input linear gain
// - full-scale amplifier output gives code 1023
// - f0 bits 15:13 front-end bias, default 4
// - f1 bit 0 sleeps all, needs recalibration
// - f1 bit 1 standby, reference only
// - f1 bits 9:8 sample-hold bandwidth select
// - f1 bits 13:10 black sample time constant
// - f1 bits 15:14 converter bias current
// - direct-input clamp level is 512
// - f2 bit 14 selects input path
`timescale 1ns/1ns
module cds_serial_control_regs (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       sdata,
  input  wire logic       offset_cal_done,
  output logic [7:0]      gain_code,
  output logic [2:0]      frontend_bias_current_code,
  output logic            sleep_control,
  output logic            standby_control,
  output logic [2:0]      output_test_mode,
  output logic [1:0]      sha_bandwidth_select,
  output logic [3:0]      black_sample_time_constant,
  output logic [1:0]      converter_bias_current_code,
  output logic            input_path_select,
  output logic            frontend_enable,
  output logic            amplifier_enable,
  output logic            recal_required,
  output logic            frame_active,
  output logic            frame_strobe,
  output logic [7:0]      frame_addr,
  output logic [15:0]     frame_data,
  output logic            frame_discard
);

  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef enum logic {
    ST_IDLE,
    ST_FRAME
  } phase_e;

  typedef struct packed {
    logic                                 sck_prev;
    phase_e                               phase;
    logic [cds_pkg::CNT_W-1:0]            bit_cnt;
    logic [cds_pkg::FRAME_BITS-1:0]       shift;
    logic [cds_pkg::GAIN_W-1:0]           gain;
    logic [cds_pkg::FE_BIAS_W-1:0]        fe_bias;
    logic                                 sleep;
    logic                                 standby;
    logic [cds_pkg::TEST_MODE_W-1:0]      test_mode;
    logic [cds_pkg::SHA_BW_W-1:0]         sha_bw;
    logic [cds_pkg::BLACK_TC_W-1:0]       black_tc;
    logic [cds_pkg::ADC_BIAS_W-1:0]       adc_bias;
    logic                                 input_path;
    logic                                 fe_en;
    logic                                 amp_en;
    logic                                 recal;
    logic                                 active;
    logic                                 strobe;
    logic [cds_pkg::ADDR_W-1:0]           addr;
    logic [cds_pkg::DATA_W-1:0]           data;
    logic                                 discard;
  } state_s;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic addr_is(
    input logic [cds_pkg::ADDR_W-1:0] a,
    input logic [cds_pkg::ADDR_W-1:0] target
  );
    addr_is = (a == target);
  endfunction

  function automatic logic in_frontend(
    input logic [cds_pkg::ADDR_W-1:0] a
  );
    in_frontend = (a >= cds_pkg::ADDR_FRONTEND_FIRST) &&
                  (a <= cds_pkg::ADDR_FRONTEND_LAST);
  endfunction

  function automatic logic [cds_pkg::ADDR_W-1:0] frame_addr_of(
    input logic [cds_pkg::FRAME_BITS-1:0] s
  );
    frame_addr_of = s[cds_pkg::FRAME_BITS-1 -: cds_pkg::BYTE_BITS];
  endfunction

  // high byte arrives last, so it sits at the low end
  function automatic logic [cds_pkg::DATA_W-1:0] frame_data_of(
    input logic [cds_pkg::FRAME_BITS-1:0] s
  );
    frame_data_of = {s[cds_pkg::BYTE_BITS-1:0],
                     s[2*cds_pkg::BYTE_BITS-1 -: cds_pkg::BYTE_BITS]};
  endfunction

  // ---------------------------------------------
  // register write decode
  // ---------------------------------------------
  function automatic state_s write_gain_and_bias(
    input state_s                     s,
    input logic [cds_pkg::DATA_W-1:0] d
  );
    state_s r;
    r         = s;
    // one code drives both gain laws, path picks which
    r.gain    = d[cds_pkg::GAIN_LSB +: cds_pkg::GAIN_W];
    r.fe_bias = d[cds_pkg::FE_BIAS_LSB +: cds_pkg::FE_BIAS_W];
    return r;
  endfunction

  function automatic state_s write_power_filter(
    input state_s                     s,
    input logic [cds_pkg::DATA_W-1:0] d
  );
    state_s r;
    r           = s;
    r.sleep     = d[cds_pkg::SLEEP_BIT];
    r.standby   = d[cds_pkg::STANDBY_BIT];
    // stored as written; nonzero is a test mode only
    r.test_mode = d[cds_pkg::TEST_MODE_LSB +: cds_pkg::TEST_MODE_W];
    r.sha_bw    = d[cds_pkg::SHA_BW_LSB +: cds_pkg::SHA_BW_W];
    r.black_tc  = d[cds_pkg::BLACK_TC_LSB +: cds_pkg::BLACK_TC_W];
    r.adc_bias  = d[cds_pkg::ADC_BIAS_LSB +: cds_pkg::ADC_BIAS_W];
    return r;
  endfunction

  // clamp target in direct mode is fixed outside this block
  function automatic state_s write_clamp_path(
    input state_s                     s,
    input logic [cds_pkg::DATA_W-1:0] d
  );
    state_s r;
    r            = s;
    r.input_path = d[cds_pkg::INPUT_PATH_BIT];
    return r;
  endfunction

  // ---------------------------------------------
  // reset release and pin sampling
  // ---------------------------------------------
  logic       rst_sync_n;
  logic [2:0] pins_sync;
  logic       sck_s;
  logic       cs_n_s;
  logic       sdata_s;

  level_sync #(
    .WIDTH     (1),
    .RESET_VAL (32'h0)
  ) u_rst_sync (
    .clk    (ref_clk),
    .arst_n (rstn),
    .d      (1'b1),
    .q      (rst_sync_n)
  );

  // cs_n idles high so a reset never looks like a frame start
  level_sync #(
    .WIDTH     (3),
    .RESET_VAL (32'h2)
  ) u_pin_sync (
    .clk    (ref_clk),
    .arst_n (rst_sync_n),
    .d      ({sdata, cs_n, sck}),
    .q      (pins_sync)
  );

  assign sck_s   = pins_sync[0];
  assign cs_n_s  = pins_sync[1];
  assign sdata_s = pins_sync[2];

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  state_s state_reg;
  state_s state_next;

  localparam state_s STATE_RESET = '{
    sck_prev:   1'b0,
    phase:      ST_IDLE,
    bit_cnt:    '0,
    shift:      '0,
    gain:       cds_pkg::GAIN_RESET,
    fe_bias:    cds_pkg::FE_BIAS_RESET,
    sleep:      1'b0,
    standby:    1'b0,
    test_mode:  cds_pkg::TEST_MODE_RESET,
    sha_bw:     cds_pkg::SHA_BW_RESET,
    black_tc:   cds_pkg::BLACK_TC_RESET,
    adc_bias:   cds_pkg::ADC_BIAS_RESET,
    input_path: 1'b0,
    fe_en:      1'b1,
    amp_en:     1'b1,
    recal:      1'b0,
    active:     1'b0,
    strobe:     1'b0,
    addr:       '0,
    data:       '0,
    discard:    1'b0
  };

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  logic                         sck_rise;
  logic [cds_pkg::ADDR_W-1:0]   rx_addr;
  logic [cds_pkg::DATA_W-1:0]   rx_data;
  logic                         commit;
  logic                         leave_sleep;

  always_comb begin
    state_next = state_reg;
    sck_rise   = sck_s && !state_reg.sck_prev;
    // frame order is address, low byte, high byte
    rx_addr    = frame_addr_of(state_reg.shift);
    rx_data    = frame_data_of(state_reg.shift);
    commit     = 1'b0;
    leave_sleep = 1'b0;

    state_next.sck_prev = sck_s;
    state_next.strobe   = 1'b0;
    state_next.discard  = 1'b0;

    case (state_reg.phase)
      ST_IDLE: begin
        // count restarts on every chip select fall
        if (!cs_n_s) begin
          state_next.phase   = ST_FRAME;
          state_next.bit_cnt = '0;
          state_next.active  = 1'b1;
        end
      end
      ST_FRAME: begin
        if (cs_n_s) begin
          state_next.phase  = ST_IDLE;
          state_next.active = 1'b0;
          if (state_reg.bit_cnt == cds_pkg::CNT_FULL) begin
            commit = 1'b1;
          end else begin
            state_next.discard = 1'b1;
          end
        end else if (sck_rise) begin
          // msb first into the low end; extra clocks poison the frame
          state_next.shift = {state_reg.shift[cds_pkg::FRAME_BITS-2:0], sdata_s};
          if (state_reg.bit_cnt != cds_pkg::CNT_OVER) begin
            state_next.bit_cnt = state_reg.bit_cnt + 5'h1;
          end
        end
      end
      default: begin
        state_next.phase  = ST_IDLE;
        state_next.active = 1'b0;
      end
    endcase

    if (commit) begin
      // every address leaves on the frame port for the timing side
      state_next.strobe = 1'b1;
      state_next.addr   = rx_addr;
      state_next.data   = rx_data;
      if (in_frontend(rx_addr)) begin
        if (addr_is(rx_addr, cds_pkg::ADDR_GAIN_AND_BIAS)) begin
          state_next = write_gain_and_bias(state_next, rx_data);
        end
        if (addr_is(rx_addr, cds_pkg::ADDR_POWER_FILTER)) begin
          state_next = write_power_filter(state_next, rx_data);
          // only a 1 to 0 sleep write asks for a new calibration
          leave_sleep = state_reg.sleep && !rx_data[cds_pkg::SLEEP_BIT];
        end
        if (addr_is(rx_addr, cds_pkg::ADDR_CLAMP_PATH)) begin
          state_next = write_clamp_path(state_next, rx_data);
        end
      end
    end

    // sleep gates everything, standby keeps only the reference
    state_next.fe_en  = !state_next.sleep;
    state_next.amp_en = !state_next.sleep && !state_next.standby;

    // set wins over the calibration acknowledge
    if (leave_sleep) begin
      state_next.recal = 1'b1;
    end else if (offset_cal_done) begin
      state_next.recal = 1'b0;
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  // one register for the whole state keeps reset in one place
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign gain_code                   = state_reg.gain;
  assign frontend_bias_current_code  = state_reg.fe_bias;
  assign sleep_control               = state_reg.sleep;
  assign standby_control             = state_reg.standby;
  assign output_test_mode            = state_reg.test_mode;
  assign sha_bandwidth_select        = state_reg.sha_bw;
  assign black_sample_time_constant  = state_reg.black_tc;
  assign converter_bias_current_code = state_reg.adc_bias;
  assign input_path_select           = state_reg.input_path;
  assign frontend_enable             = state_reg.fe_en;
  assign amplifier_enable            = state_reg.amp_en;
  assign recal_required              = state_reg.recal;
  assign frame_active                = state_reg.active;
  assign frame_strobe                = state_reg.strobe;
  assign frame_addr                  = state_reg.addr;
  assign frame_data                  = state_reg.data;
  assign frame_discard               = state_reg.discard;

endmodule

// ---- dv/cds_serial_control_regs_checker.sv ----
// Purpose: port-level checks on the serial control block
// Assumes: one clock domain, ref_clk
// Notes:   bound to the design top below
`timescale 1ns/1ns
module cds_serial_control_regs_checker (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        cs_n,
  input wire logic        offset_cal_done,
  input wire logic [7:0]  gain_code,
  input wire logic [2:0]  frontend_bias_current_code,
  input wire logic        sleep_control,
  input wire logic        standby_control,
  input wire logic [15:0] frame_data,
  input wire logic        frontend_enable,
  input wire logic        amplifier_enable,
  input wire logic        recal_required,
  input wire logic        frame_active,
  input wire logic        frame_strobe,
  input wire logic        frame_discard
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_strobe_pulse: assert property (frame_strobe |=> !frame_strobe) else $error("strobe longer than one cycle");
  chk_strobe_excl: assert property (!(frame_strobe && frame_discard)) else $error("strobe with discard");
  chk_discard_hold: assert property (frame_discard |-> $stable({gain_code, frontend_bias_current_code, frame_data}))
    else $error("discard changed registers");
  chk_regs_hold: assert property (!frame_strobe |-> $stable({gain_code, sleep_control, standby_control, frame_data}))
    else $error("register moved without frame");
  chk_cs_high: assert property (frame_strobe |-> cs_n && $past(cs_n, 2) && !frame_active)
    else $error("update before chip select high");
  chk_frame_start: assert property ($fell(cs_n) |-> ##[1:4] frame_active) else $error("frame not started");
  chk_fe_enable: assert property (frontend_enable == !sleep_control) else $error("front end on in sleep");
  chk_amp_enable: assert property (amplifier_enable == !(sleep_control || standby_control))
    else $error("amplifier on in standby");
  chk_recal_set: assert property ($fell(sleep_control) |-> recal_required) else $error("recal not flagged");
  chk_recal_clear: assert property (offset_cal_done && !frame_active && !frame_strobe |=> !recal_required)
    else $error("recal not cleared");
endmodule
bind cds_serial_control_regs cds_serial_control_regs_checker i_chk (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n),
  .offset_cal_done(offset_cal_done), .gain_code(gain_code), .frontend_bias_current_code(frontend_bias_current_code),
  .sleep_control(sleep_control), .standby_control(standby_control), .frame_data(frame_data),
  .frontend_enable(frontend_enable), .amplifier_enable(amplifier_enable), .recal_required(recal_required),
  .frame_active(frame_active), .frame_strobe(frame_strobe), .frame_discard(frame_discard));

// ---- dv/host_serial_model.sv ----
// Purpose: host side of the three-wire serial write link
// Assumes: serial clock period 800 ns, idle low
// Notes:   data line shows the inverse of its last bit when released
`timescale 1ns/1ns
module host_serial_model (
  output logic sck,
  output logic cs_n,
  output logic sdata
);
  initial begin
    sck   = 1'b0;
    cs_n  = 1'b1;
    sdata = 1'b0;
  end
  // n other than 24 makes a faulty frame on purpose
  task automatic send_frame(input logic [7:0] a, input logic [15:0] d, input int n);
    logic [23:0] bits;
    bits = {a, d[7:0], d[15:8]};
    cs_n = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      sdata = (i < 24) ? bits[23-i] : 1'b0;
      #400 sck = 1'b1;
      #400 sck = 1'b0;
    end
    #400 cs_n = 1'b1;
    sdata = ~sdata;
    #800;
  endtask
endmodule

// ---- dv/test_cds_serial_control_regs.sv ----
// Purpose: self-checking bench for the serial control block
// Assumes: expected results queued by the driver, checked by a monitor
// Notes:   register model lives here, not in the design
`timescale 1ns/1ns
module test_cds_serial_control_regs;
  logic ref_clk = 1'b0, rstn = 1'b0, offset_cal_done = 1'b0;
  wire sck, cs_n, sdata;
  logic [7:0] gain_code, frame_addr;
  logic [2:0] frontend_bias_current_code, output_test_mode;
  logic [1:0] sha_bandwidth_select, converter_bias_current_code;
  logic [3:0] black_sample_time_constant;
  logic [15:0] frame_data;
  logic sleep_control, standby_control, input_path_select, frontend_enable, amplifier_enable;
  logic recal_required, frame_active, frame_strobe, frame_discard;
  int n_mismatch = 0, n_compared = 0;
  logic [31:0] seed = 32'h8c2c1e3f;
  logic [52:0] q[$];
  logic [7:0] m_gain, m_addr;
  logic [2:0] m_bias;
  logic [15:0] m_f1, m_data, d;
  logic m_path, m_recal;
  always #50 ref_clk = ~ref_clk;
  host_serial_model host (.sck(sck), .cs_n(cs_n), .sdata(sdata));
  cds_serial_control_regs i_cds_serial_control_regs (.ref_clk(ref_clk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
    .sdata(sdata), .offset_cal_done(offset_cal_done), .gain_code(gain_code),
    .frontend_bias_current_code(frontend_bias_current_code), .sleep_control(sleep_control),
    .standby_control(standby_control), .output_test_mode(output_test_mode),
    .sha_bandwidth_select(sha_bandwidth_select), .black_sample_time_constant(black_sample_time_constant),
    .converter_bias_current_code(converter_bias_current_code), .input_path_select(input_path_select),
    .frontend_enable(frontend_enable), .amplifier_enable(amplifier_enable), .recal_required(recal_required),
    .frame_active(frame_active), .frame_strobe(frame_strobe), .frame_addr(frame_addr), .frame_data(frame_data),
    .frame_discard(frame_discard));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [52:0] ev(input logic disc);
    return {disc, m_addr, m_data, m_gain, m_bias, m_f1[0], m_f1[1], m_f1[4:2], m_f1[9:8], m_f1[13:10],
            m_f1[15:14], m_path, ~m_f1[0], ~(m_f1[0] | m_f1[1]), m_recal};
  endfunction
  function automatic logic [52:0] obs();
    return {frame_discard, frame_addr, frame_data, gain_code, frontend_bias_current_code, sleep_control,
            standby_control, output_test_mode, sha_bandwidth_select, black_sample_time_constant,
            converter_bias_current_code, input_path_select, frontend_enable, amplifier_enable, recal_required};
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic model_reset();
    m_gain = 8'h00; m_bias = 3'h4; m_f1 = 16'h0000; m_path = 1'b0;
    m_recal = 1'b0; m_addr = 8'h00; m_data = 16'h0000;
  endtask
  task automatic frame(input logic [7:0] a, input logic [15:0] dv, input int n);
    if (n == 24) begin
      m_addr = a;
      m_data = dv;
      if (a == 8'hf0) begin
        m_gain = dv[7:0];
        m_bias = dv[15:13];
      end
      if (a == 8'hf1) begin
        if (m_f1[0] && !dv[0]) m_recal = 1'b1;
        m_f1 = dv;
      end
      if (a == 8'hf2) m_path = dv[14];
    end
    q.push_back(ev(n != 24));
    @(posedge ref_clk);
    #10;
    host.send_frame(a, dv, n);
    for (int k = 0; k < 30 && q.size() > 0; k++) @(posedge ref_clk);
    check("pending", q.size(), 0);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------
  // monitor and watchdog
  // ---------------------------------------------
  initial forever begin
    @(posedge ref_clk);
    #1;
    if (frame_strobe === 1'b1 || frame_discard === 1'b1) begin
      if (q.size() == 0) check("unexpected frame", 1, 0);
      else check("frame", obs(), q.pop_front());
    end
  end
  initial begin
    #3000000;
    n_mismatch++;
    report_and_stop();
  end
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial begin
    model_reset();
    repeat (8) @(posedge ref_clk);
    #10 rstn = 1'b1;
    check("reset", obs(), ev(1'b0));
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 12; i++) begin
      d = 16'(rnd());
      case (i % 4)
        0: frame(8'hf0, d, 24);
        1: frame(8'hf1, d & 16'hffe3, 24);
        2: frame(8'hf2, d, 24);
        default: frame((i == 3) ? 8'h00 : (i == 7) ? 8'hff : {4'h3, d[3:0]}, d, 24);
      endcase
    end
    frame(8'hf0, 16'(rnd()), 23);
    frame(8'hf1, 16'(rnd()), 25);
    frame(8'hf0, 16'(rnd()), 1);
    frame(8'hf1, 16'h0001, 24);
    frame(8'hf1, 16'h0002, 24);
    @(posedge ref_clk);
    #10 offset_cal_done = 1'b1;
    @(posedge ref_clk);
    #10 offset_cal_done = 1'b0;
    m_recal = 1'b0;
    @(posedge ref_clk);
    check("recal", obs(), ev(1'b0));
    frame(8'hf1, 16'h0000, 24);
    repeat (50) @(posedge ref_clk);
    #10 rstn = 1'b0;
    model_reset();
    #20 check("mid reset", obs(), ev(1'b0));
    repeat (3) @(posedge ref_clk);
    #10 rstn = 1'b1;
    repeat (8) @(posedge ref_clk);
    frame(8'hf0, 16'h80ff, 24);
    report_and_stop();
  end
endmodule
